// *** verilog/fra_defs.vh ***
`ifndef FRA_DEFS_VH
`define FRA_DEFS_VH

// One-hot controller states.
`define FRA_ST_IDLE 3'h1
`define FRA_ST_FETCH 3'h2
`define FRA_ST_PREF 3'h4

// Fields of the platform control word.
`define FRA_CTL_W 5
`define FRA_CTL_CACHE_EN 0
`define FRA_CTL_I_SPEC 1
`define FRA_CTL_I_CACHE 2
`define FRA_CTL_D_SPEC 3
`define FRA_CTL_D_CACHE 4
`define FRA_CTL_RESET 5'h17

// Power mode codes in which the flash can be read.
`define FRA_PM_RUN 3'h0
`define FRA_PM_WAIT 3'h1
`define FRA_PM_VLP_RUN 3'h2
`define FRA_PM_VLP_WAIT 3'h3

// Access sizes.
`define FRA_SZ_BYTE 2'h0
`define FRA_SZ_HALF 2'h1
`define FRA_SZ_WORD 2'h2

// Cache geometry: four sets of four ways, one word per line.
`define FRA_SET_BITS 2
`define FRA_WAY_BITS 2
`define FRA_LINES 16

`define FRA_MASK_BYTE 32'h0000_00ff
`define FRA_MASK_HALF 32'h0000_ffff
`define FRA_MASK_WORD 32'hffff_ffff

`endif

// *** verilog/fra_flash_read_accelerator.v ***
// Behaviour
// - Serve byte, halfword and word reads from the 32-bit flash array.
// - Writes to flash space never reach the array and get a bus error.
// - One-word speculation buffer prefetches the word after the latest access.
// - Cache of four sets by four ways, one word per line, invalidatable.
// - Buffer hit or enabled-cache hit answers within one system clock when no prefetch is in flight.
// - Reset enables cache, instruction speculation and caching, data caching only.
// - Act only while a master accesses flash; otherwise stay idle.
// - Operate only in run, wait and their very-low-power variants.
// - Held disabled in any power mode where flash cannot be read.
// - Separate speculation and caching enables for instruction and data accesses.
// - Flash organisation status shapes every array address the block forms.
`timescale 1ns/1ps
`include "fra_defs.vh"

module fra_flash_read_accelerator #(
  parameter ADDR_W = 18
)(
  CLK,
  RST_B,
  REQ_VALID,
  REQ_WRITE,
  REQ_INSTR,
  REQ_SIZE,
  REQ_ADDR,
  RSP_VALID,
  RSP_ERROR,
  RSP_DATA,
  CTRL_WR,
  CTRL_DATA,
  CTRL_STATE,
  CACHE_INV,
  PWR_MODE,
  FL_ADDR_MASK,
  FL_RD,
  FL_ADDR,
  FL_RVALID,
  FL_RDATA,
  ACCEL_BUSY
);
  localparam WW = ADDR_W - 2;
  localparam TW = WW - `FRA_SET_BITS;

  input wire CLK;
  input wire RST_B;
  input wire REQ_VALID;
  input wire REQ_WRITE;
  input wire REQ_INSTR;
  input wire [1:0] REQ_SIZE;
  input wire [ADDR_W-1:0] REQ_ADDR;
  output reg RSP_VALID;
  output reg RSP_ERROR;
  output reg [31:0] RSP_DATA;
  input wire CTRL_WR;
  input wire [`FRA_CTL_W-1:0] CTRL_DATA;
  output reg [`FRA_CTL_W-1:0] CTRL_STATE;
  input wire CACHE_INV;
  input wire [2:0] PWR_MODE;
  input wire [WW-1:0] FL_ADDR_MASK;
  output reg FL_RD;
  output reg [WW-1:0] FL_ADDR;
  input wire FL_RVALID;
  input wire [31:0] FL_RDATA;
  output reg ACCEL_BUSY;

  reg [2:0] st_r;
  reg [`FRA_LINES-1:0] vld_r;
  reg [TW-1:0] tag_mem [0:`FRA_LINES-1];
  reg [31:0] dat_mem [0:`FRA_LINES-1];
  reg [`FRA_WAY_BITS-1:0] rr_r [0:(1<<`FRA_SET_BITS)-1];
  reg buf_v_r;
  reg [WW-1:0] buf_word_r;
  reg [31:0] buf_data_r;
  reg alloc_we;
  reg [`FRA_SET_BITS+`FRA_WAY_BITS-1:0] alloc_idx;
  integer i;

  wire [WW-1:0] req_word = REQ_ADDR[ADDR_W-1:2] & FL_ADDR_MASK;
  wire [WW-1:0] next_word = (req_word + {{(WW-1){1'b0}}, 1'b1}) & FL_ADDR_MASK;
  wire [`FRA_SET_BITS-1:0] req_set = req_word[`FRA_SET_BITS-1:0];
  wire [TW-1:0] req_tag = req_word[WW-1:`FRA_SET_BITS];
  // Flash is readable only in the run and wait families.
  wire pwr_ok = (PWR_MODE == `FRA_PM_RUN) || (PWR_MODE == `FRA_PM_WAIT) ||
    (PWR_MODE == `FRA_PM_VLP_RUN) || (PWR_MODE == `FRA_PM_VLP_WAIT);
  wire cache_on = CTRL_STATE[`FRA_CTL_CACHE_EN] && (REQ_INSTR ?
    CTRL_STATE[`FRA_CTL_I_CACHE] : CTRL_STATE[`FRA_CTL_D_CACHE]);
  wire spec_on = REQ_INSTR ? CTRL_STATE[`FRA_CTL_I_SPEC] : CTRL_STATE[`FRA_CTL_D_SPEC];
  wire buf_hit = buf_v_r && (buf_word_r == req_word);
  wire next_buffered = buf_v_r && (buf_word_r == next_word);
  // A request is not taken while its answer is still on the bus, or in an invalidate cycle.
  wire accept = REQ_VALID && !RSP_VALID && !CACHE_INV;

  wire [(1<<`FRA_WAY_BITS)-1:0] way_hit;
  wire [31:0] way_data [0:(1<<`FRA_WAY_BITS)-1];
  genvar w;
  generate
    for (w = 0; w < (1 << `FRA_WAY_BITS); w = w + 1)
    begin : g_way
      // A genvar cannot be part-selected, so the way number gets a sized constant.
      localparam [`FRA_WAY_BITS-1:0] WAY = w;
      wire [`FRA_SET_BITS+`FRA_WAY_BITS-1:0] li = {req_set, WAY};
      assign way_hit[w] = vld_r[li] && (tag_mem[li] == req_tag);
      assign way_data[w] = way_hit[w] ? dat_mem[li] : 32'h0000_0000;
    end
  endgenerate
  wire cache_hit = cache_on && (|way_hit);
  wire [31:0] hit_data = way_data[0] | way_data[1] | way_data[2] | way_data[3];

  reg [31:0] lane_mask;
  always @*
  begin
    case (REQ_SIZE)
      `FRA_SZ_BYTE: lane_mask = `FRA_MASK_BYTE << {REQ_ADDR[1:0], 3'h0};
      `FRA_SZ_HALF: lane_mask = `FRA_MASK_HALF << {REQ_ADDR[1], 4'h0};
      default: lane_mask = `FRA_MASK_WORD;
    endcase
  end

  // Allocation happens when a demand miss returns.
  always @*
  begin
    alloc_we = (st_r == `FRA_ST_FETCH) && FL_RVALID && cache_on && !CACHE_INV;
    alloc_idx = {req_set, rr_r[req_set]};
  end

  // Line contents need no reset; the valid bits guard them.
  always @(posedge CLK)
  begin
    if (alloc_we)
    begin
      tag_mem[alloc_idx] <= req_tag;
      dat_mem[alloc_idx] <= FL_RDATA;
    end
  end

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_r <= `FRA_ST_IDLE;
      vld_r <= {`FRA_LINES{1'b0}};
      for (i = 0; i < (1 << `FRA_SET_BITS); i = i + 1)
        rr_r[i] <= {`FRA_WAY_BITS{1'b0}};
      buf_v_r <= 1'b0;
      buf_word_r <= {WW{1'b0}};
      buf_data_r <= 32'h0000_0000;
      RSP_VALID <= 1'b0;
      RSP_ERROR <= 1'b0;
      RSP_DATA <= 32'h0000_0000;
      CTRL_STATE <= `FRA_CTL_RESET;
      FL_RD <= 1'b0;
      FL_ADDR <= {WW{1'b0}};
      ACCEL_BUSY <= 1'b0;
    end
    else
    begin
      RSP_VALID <= 1'b0;
      RSP_ERROR <= 1'b0;
      FL_RD <= 1'b0;
      // Controls are taken as written; software keeps them still during flash traffic.
      if (CTRL_WR)
        CTRL_STATE <= CTRL_DATA;
      case (st_r)
        `FRA_ST_IDLE:
        begin
          if (accept)
          begin
            if (REQ_WRITE || !pwr_ok)
            begin
              RSP_VALID <= 1'b1;
              RSP_ERROR <= 1'b1;
              RSP_DATA <= 32'h0000_0000;
            end
            else if (buf_hit || cache_hit)
            begin
              RSP_VALID <= 1'b1;
              RSP_DATA <= (buf_hit ? buf_data_r : hit_data) & lane_mask;
              if (spec_on && !next_buffered)
              begin
                FL_RD <= 1'b1;
                FL_ADDR <= next_word;
                st_r <= `FRA_ST_PREF;
              end
            end
            else
            begin
              FL_RD <= 1'b1;
              FL_ADDR <= req_word;
              st_r <= `FRA_ST_FETCH;
            end
          end
        end
        `FRA_ST_FETCH:
        begin
          if (FL_RVALID)
          begin
            RSP_VALID <= 1'b1;
            RSP_DATA <= FL_RDATA & lane_mask;
            if (alloc_we)
            begin
              vld_r[alloc_idx] <= 1'b1;
              rr_r[req_set] <= rr_r[req_set] + {{(`FRA_WAY_BITS-1){1'b0}}, 1'b1};
            end
            // A mode change during the fetch must not start a prefetch from an unreadable array.
            if (spec_on && !next_buffered && pwr_ok)
            begin
              FL_RD <= 1'b1;
              FL_ADDR <= next_word;
              st_r <= `FRA_ST_PREF;
            end
            else
              st_r <= `FRA_ST_IDLE;
          end
        end
        `FRA_ST_PREF:
        begin
          if (FL_RVALID)
          begin
            buf_v_r <= 1'b1;
            buf_word_r <= FL_ADDR;
            buf_data_r <= FL_RDATA;
            st_r <= `FRA_ST_IDLE;
          end
        end
        default: st_r <= `FRA_ST_IDLE;
      endcase
      // Invalidate overrides any fill landing in the same cycle.
      if (CACHE_INV)
      begin
        vld_r <= {`FRA_LINES{1'b0}};
        buf_v_r <= 1'b0;
      end
      ACCEL_BUSY <= (st_r != `FRA_ST_IDLE) || accept;
    end
  end
endmodule

// *** verif/fra_flash_model.sv ***
`timescale 1ns/1ps
module fra_flash_model (
  input wire CLK, RST_B, FL_RD,
  input wire [15:0] FL_ADDR,
  input wire [3:0] FL_LAT,
  output reg FL_RVALID,
  output reg [31:0] FL_RDATA
);
  reg [4:0] cnt_r;
  // Data toggles outside the answer cycle, so a sample taken one cycle late reads the inverted word and does not match.
  always @(posedge CLK or negedge RST_B)
    if (!RST_B)
      {cnt_r, FL_RVALID, FL_RDATA} <= 38'h0;
    else
    begin
      FL_RVALID <= cnt_r == 5'h1;
      FL_RDATA <= cnt_r == 5'h1 ? {~FL_ADDR, FL_ADDR} : ~FL_RDATA;
      cnt_r <= FL_RD ? {1'b0, FL_LAT} + 5'h1 : cnt_r - {4'h0, cnt_r != 5'h0};
    end
endmodule

// *** verif/fra_sva.sv ***
`timescale 1ns/1ps
module fra_sva #(
  parameter WW = 16
)(
  input wire CLK, RST_B, REQ_VALID, REQ_WRITE, RSP_VALID, RSP_ERROR,
  input wire CTRL_WR, CACHE_INV, FL_RD, ACCEL_BUSY,
  input wire [31:0] RSP_DATA,
  input wire [4:0] CTRL_DATA, CTRL_STATE,
  input wire [2:0] PWR_MODE,
  input wire [WW-1:0] FL_ADDR_MASK, FL_ADDR
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  wire idle = !RSP_VALID && !ACCEL_BUSY && !CACHE_INV;
  a_write_err: assert property (REQ_VALID && REQ_WRITE && idle |=> RSP_ERROR)
    else $error("write not refused");
  a_mode_err: assert property (REQ_VALID && PWR_MODE[2] && idle |=> RSP_ERROR)
    else $error("read in off mode");
  a_err_form: assert property (RSP_ERROR |-> RSP_VALID && RSP_DATA == 32'h0)
    else $error("bad error answer");
  a_off_read: assert property (PWR_MODE[2] |-> !FL_RD) else $error("array read");
  a_reset_ctl: assert property ($rose(RST_B) |-> CTRL_STATE == 5'h17)
    else $error("bad reset control");
  a_ctl_load: assert property (CTRL_WR |=> CTRL_STATE == $past(CTRL_DATA))
    else $error("control not loaded");
  a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID) else $error("long answer");
  a_rsp_cause: assert property (RSP_VALID |-> $past(REQ_VALID)) else $error("no request");
  a_fl_mask: assert property (FL_RD |-> (FL_ADDR & ~FL_ADDR_MASK) == {WW{1'b0}})
    else $error("mask ignored");
  a_busy_take: assert property (REQ_VALID && idle |=> ACCEL_BUSY)
    else $error("request not taken");
  a_stay_idle: assert property (!REQ_VALID && !ACCEL_BUSY |=> !ACCEL_BUSY && !FL_RD)
    else $error("activity without request");
endmodule
bind fra_flash_read_accelerator fra_sva #(.WW(WW)) i_fra_sva (
  .CLK(CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
  .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .CTRL_WR(CTRL_WR), .CACHE_INV(CACHE_INV),
  .FL_RD(FL_RD), .ACCEL_BUSY(ACCEL_BUSY), .RSP_DATA(RSP_DATA), .CTRL_DATA(CTRL_DATA),
  .CTRL_STATE(CTRL_STATE), .PWR_MODE(PWR_MODE), .FL_ADDR_MASK(FL_ADDR_MASK),
  .FL_ADDR(FL_ADDR)
);

// *** verif/fra_flash_read_accelerator_tb.sv ***
`timescale 1ns/1ps
module fra_flash_read_accelerator_tb;
  reg CLK = 1'b0, RST_B = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_INSTR = 1'b0;
  reg CTRL_WR = 1'b0, CACHE_INV = 1'b0;
  reg [1:0] REQ_SIZE = 2'h0;
  reg [2:0] PWR_MODE = 3'h0;
  reg [3:0] FL_LAT = 4'h0;
  reg [4:0] CTRL_DATA = 5'h0;
  reg [15:0] FL_ADDR_MASK = 16'h0fff;
  reg [17:0] REQ_ADDR = 18'h0;
  wire RSP_VALID, RSP_ERROR, FL_RD, FL_RVALID, ACCEL_BUSY;
  wire [31:0] RSP_DATA, FL_RDATA;
  wire [4:0] CTRL_STATE;
  wire [15:0] FL_ADDR;
  integer fails = 0, n_compared = 0, i;
  reg [15:0] w;
  fra_flash_read_accelerator i_fra_flash_read_accelerator (
    .CLK(CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_INSTR(REQ_INSTR), .REQ_SIZE(REQ_SIZE), .REQ_ADDR(REQ_ADDR),
    .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .RSP_DATA(RSP_DATA),
    .CTRL_WR(CTRL_WR), .CTRL_DATA(CTRL_DATA), .CTRL_STATE(CTRL_STATE),
    .CACHE_INV(CACHE_INV), .PWR_MODE(PWR_MODE), .FL_ADDR_MASK(FL_ADDR_MASK),
    .FL_RD(FL_RD), .FL_ADDR(FL_ADDR), .FL_RVALID(FL_RVALID), .FL_RDATA(FL_RDATA),
    .ACCEL_BUSY(ACCEL_BUSY)
  );
  fra_flash_model i_fra_flash_model (
    .CLK(CLK), .RST_B(RST_B), .FL_RD(FL_RD), .FL_ADDR(FL_ADDR), .FL_LAT(FL_LAT),
    .FL_RVALID(FL_RVALID), .FL_RDATA(FL_RDATA)
  );
  always #2 CLK = ~CLK;
  task chk(input ok);
    begin
      n_compared = n_compared + 1;
      if (ok !== 1'b1)
        $display("ERROR %0t check %0d", $time, n_compared);
      fails = fails + (ok !== 1'b1);
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Idle cycles first, so a prefetch launched by the last answer has landed.
  task acc(input wr, input ins, input [1:0] sz, input [17:0] a, input [1:0] hit);
    integer n;
    reg e;
    begin
      repeat (4) @(posedge CLK);
      e = wr | PWR_MODE[2];
      w = a[17:2] & FL_ADDR_MASK;
      {REQ_VALID, REQ_WRITE, REQ_INSTR, REQ_SIZE, REQ_ADDR} <= {1'b1, wr, ins, sz, a};
      for (n = 0; RSP_VALID !== 1'b1 && n < 50; n = n + 1)
        @(posedge CLK);
      REQ_VALID <= 1'b0;
      chk(RSP_ERROR === e && RSP_DATA === (e ? 32'h0 : {~w, w} & (sz == 2'h0 ?
        32'hff << {a[1:0], 3'h0} : sz == 2'h1 ? 32'hffff << {a[1], 4'h0} : 32'hffffffff)));
      chk(n < 50 && (hit[1] || (n == 2) == hit[0]));
    end
  endtask
  task ctl(input [4:0] d, input inv);
    begin
      repeat (4) @(posedge CLK);
      {CTRL_WR, CTRL_DATA, CACHE_INV} <= {1'b1, d, inv};
      @(posedge CLK);
      {CTRL_WR, CACHE_INV} <= 2'h0;
      @(posedge CLK);
      chk(CTRL_STATE === d);
    end
  endtask
  initial
  begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    chk(CTRL_STATE === 5'h17 && RSP_VALID === 1'b0);
    acc(0, 1, 2'h2, 18'h10100, 2'h0);
    acc(0, 1, 2'h2, 18'h00100, 2'h1);
    acc(0, 1, 2'h2, 18'h00100, 2'h1);
    acc(0, 1, 2'h2, 18'h00104, 2'h1);
    for (i = 0; i < 6; i = i + 1)
      acc(0, 0, 2'(i / 4), 18'h100 + 18'(i < 4 ? i : 2 * i - 8), 2'h1);
    for (i = 0; i < 8; i = i + 1)
    begin
      PWR_MODE <= 3'(i ^ 4);
      acc(0, 0, 2'h2, 18'h00100, 2'h1);
    end
    acc(1, 0, 2'h2, 18'h00100, 2'h1);
    acc(0, 0, 2'h2, 18'h00300, 2'h0);
    acc(0, 0, 2'h2, 18'h00304, 2'h0);
    ctl(5'h1f, 0);
    acc(0, 0, 2'h2, 18'h00400, 2'h0);
    acc(0, 0, 2'h2, 18'h00404, 2'h1);
    ctl(5'h1f, 1);
    acc(0, 0, 2'h2, 18'h00408, 2'h0);
    acc(0, 1, 2'h2, 18'h00100, 2'h0);
    ctl(5'h15, 1);
    for (i = 0; i < 32; i = i + 1)
      acc(0, 0, 2'h2, 18'h2000 + 18'(i % 16 * 4), 2'(i / 16));
    ctl(5'h00, 1);
    FL_LAT <= 4'h5;
    acc(0, 1, 2'h2, 18'h00500, 2'h0);
    acc(0, 1, 2'h2, 18'h00500, 2'h0);
    end_of_test;
  end
  initial
  begin
    #20000 fails = fails + 1;
    end_of_test;
  end
endmodule
